// ===== hw/cmb_check.sv
// Placement checker for one command's buffer usage.
// Assumes the command fetch logic reports where each structure of a command lives.
module cmb_check (
  // Command placement
  input wire logic chk_valid_i,
  input wire logic sq_in_buf_i,
  input wire logic list_in_buf_i,
  input wire logic list_split_i,
  input wire logic data_in_buf_i,
  input wire logic data_split_i,
  input wire logic queue_split_i,
  input wire logic queue_noncontig_i,
  input wire logic [4:0] support_i,
  // Verdict
  output logic bad_o,
  output logic [7:0] status_o
);

  always_comb begin
    bad_o = 1'b0;
    if (chk_valid_i) begin
      bad_o = queue_split_i | queue_noncontig_i | list_split_i | data_split_i;
      if (list_in_buf_i && (!sq_in_buf_i || !support_i[cmb_pkg::SUP_LIST_POS])) begin
        bad_o = 1'b1;
      end
      if (data_in_buf_i && !support_i[cmb_pkg::SUP_WR_DATA_POS]) begin
        bad_o = 1'b1;
      end
    end
    status_o = bad_o ? cmb_pkg::STATUS_INVALID_CMB_USE : cmb_pkg::STATUS_SUCCESS;
  end

endmodule

// ===== hw/cmb_top.sv
// Controller memory buffer: host-visible read/write memory with placement checking.
// Assumes a transaction-layer front end that presents decoded memory requests on
// the controller clock and accepts completion data when ready.
// ----------------------------------------------------------------
// ----------------------------------------------------------------
module cmb_top (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // Window configuration and capabilities
  input wire logic [31:0] window_base_i,
  output logic [4:0] support_o,
  output logic base_ok_o,
  // Host request, one dword beat per cycle
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic req_write_i,
  input wire logic [31:0] req_addr_i,
  input wire logic [5:0] req_len_i,
  input wire logic [3:0] req_first_be_i,
  input wire logic [3:0] req_last_be_i,
  input wire logic [31:0] req_wdata_i,
  output logic req_hit_o,
  // Read completion data
  output logic cpl_valid_o,
  input wire logic cpl_ready_i,
  output logic [31:0] cpl_data_o,
  output logic cpl_last_o,
  // Controller-internal port for queues, lists and data
  input wire logic int_rd_i,
  input wire logic [9:0] int_word_i,
  output logic [31:0] int_rdata_o,
  // Command placement check
  input wire logic chk_valid_i,
  input wire logic sq_in_buf_i,
  input wire logic list_in_buf_i,
  input wire logic list_split_i,
  input wire logic data_in_buf_i,
  input wire logic data_split_i,
  input wire logic queue_split_i,
  input wire logic queue_noncontig_i,
  output logic chk_done_o,
  output logic chk_bad_o,
  output logic [7:0] chk_status_o
);

  // ----------------------------------------------------------------
  // Window decode
  // ----------------------------------------------------------------
  function automatic logic in_window(input logic [31:0] addr, input logic [31:0] base);
    in_window = (addr[31:cmb_pkg::BUF_ADDR_W] == base[31:cmb_pkg::BUF_ADDR_W]);
  endfunction

  // The window is a 4 KB page, so base_ok_o requires the low 12 base bits to be zero.
  assign base_ok_o = (window_base_i[cmb_pkg::ALIGN_MIN_BITS-1:0] == 12'h000);
  assign support_o = cmb_pkg::SUPPORT_FLAGS;
  assign req_hit_o = req_valid_i & in_window(req_addr_i, window_base_i);

  // ----------------------------------------------------------------
  // Memory: no reset, contents undefined until the host writes them
  // ----------------------------------------------------------------
  logic [31:0] mem [cmb_pkg::BUF_WORDS];

  cmb_pkg::cmb_state_type state_q, state_d;
  logic [9:0] word_q, word_d;
  logic [5:0] left_q, left_d;
  logic first_q, first_d;
  logic [3:0] last_be_q, last_be_d;
  logic [31:0] cpl_data_q, cpl_data_d;
  logic cpl_valid_q, cpl_valid_d;
  logic cpl_last_q, cpl_last_d;
  logic [31:0] int_rdata_q;
  logic wr_en;
  logic [3:0] wr_be;
  logic [31:0] mem_rd;
  wire logic [31:0] wr_word;

  assign mem_rd = mem[word_q];

  // ----------------------------------------------------------------
  // Transfer sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    word_d = word_q;
    left_d = left_q;
    first_d = first_q;
    last_be_d = last_be_q;
    cpl_data_d = cpl_data_q;
    cpl_valid_d = cpl_valid_q;
    cpl_last_d = cpl_last_q;
    wr_en = 1'b0;
    wr_be = 4'h0;
    req_ready_o = 1'b0;
    if (cpl_valid_q && cpl_ready_i) begin
      cpl_valid_d = 1'b0;
    end
    case (state_q)
      cmb_pkg::CMB_IDLE: begin
        req_ready_o = 1'b1;
        if (req_hit_o) begin
          word_d = req_addr_i[cmb_pkg::BUF_ADDR_W-1:2];
          left_d = req_len_i;
          first_d = 1'b1;
          last_be_d = req_last_be_i;
          state_d = req_write_i ? cmb_pkg::CMB_WRITE : cmb_pkg::CMB_READ;
        end
      end
      cmb_pkg::CMB_WRITE: begin
        req_ready_o = req_valid_i;
        if (req_valid_i) begin
          wr_en = 1'b1;
          wr_be = first_q ? req_first_be_i : 4'hf;
          if (left_q == 6'h01) begin
            wr_be = first_q ? (req_first_be_i & last_be_q) : last_be_q;
            state_d = cmb_pkg::CMB_IDLE;
          end
          first_d = 1'b0;
          word_d = word_q + 10'h001;
          left_d = left_q - 6'h01;
        end
      end
      cmb_pkg::CMB_READ: begin
        if (!cpl_valid_q || cpl_ready_i) begin
          cpl_valid_d = 1'b1;
          cpl_data_d = mem_rd;
          cpl_last_d = (left_q == 6'h01);
          word_d = word_q + 10'h001;
          left_d = left_q - 6'h01;
          if (left_q == 6'h01) begin
            state_d = cmb_pkg::CMB_IDLE;
          end
        end
      end
      default: begin
        state_d = cmb_pkg::CMB_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= cmb_pkg::CMB_IDLE;
      word_q <= 10'h000;
      left_q <= 6'h00;
      first_q <= 1'b0;
      last_be_q <= 4'h0;
      cpl_data_q <= 32'h0000_0000;
      cpl_valid_q <= 1'b0;
      cpl_last_q <= 1'b0;
    end else begin
      state_q <= state_d;
      word_q <= word_d;
      left_q <= left_d;
      first_q <= first_d;
      last_be_q <= last_be_d;
      cpl_data_q <= cpl_data_d;
      cpl_valid_q <= cpl_valid_d;
      cpl_last_q <= cpl_last_d;
    end
  end

  // ----------------------------------------------------------------
  // Byte lanes and internal port
  // ----------------------------------------------------------------
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++) begin : g_lane
      assign wr_word[lane*8 +: 8] = wr_be[lane] ? req_wdata_i[lane*8 +: 8] : mem_rd[lane*8 +: 8];
    end
  endgenerate

  always_ff @(posedge ref_clk_i) begin
    if (wr_en) begin
      mem[word_q] <= wr_word;
    end
  end

  // Queues and lists are read through the same array the host writes.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      int_rdata_q <= 32'h0000_0000;
    end else if (int_rd_i) begin
      int_rdata_q <= mem[int_word_i];
    end
  end

  assign int_rdata_o = int_rdata_q;
  assign cpl_valid_o = cpl_valid_q;
  assign cpl_data_o = cpl_data_q;
  assign cpl_last_o = cpl_last_q;

  // ----------------------------------------------------------------
  // Placement verdict
  // ----------------------------------------------------------------
  logic chk_bad;
  logic [7:0] chk_status;
  logic chk_done_q;
  logic chk_bad_q;
  logic [7:0] chk_status_q;

  cmb_check u_check (
    .chk_valid_i(chk_valid_i),
    .sq_in_buf_i(sq_in_buf_i),
    .list_in_buf_i(list_in_buf_i),
    .list_split_i(list_split_i),
    .data_in_buf_i(data_in_buf_i),
    .data_split_i(data_split_i),
    .queue_split_i(queue_split_i),
    .queue_noncontig_i(queue_noncontig_i),
    .support_i(support_o),
    .bad_o(chk_bad),
    .status_o(chk_status)
  );

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      chk_done_q <= 1'b0;
      chk_bad_q <= 1'b0;
      chk_status_q <= 8'h00;
    end else begin
      chk_done_q <= chk_valid_i;
      chk_bad_q <= chk_bad;
      chk_status_q <= chk_status;
    end
  end

  assign chk_done_o = chk_done_q;
  assign chk_bad_o = chk_bad_q;
  assign chk_status_o = chk_status_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_bad_status;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    chk_valid_i && list_in_buf_i && !sq_in_buf_i |=> chk_bad_o && chk_status_o == 8'h2a;
  endproperty
  a_bad_status: assert property (p_bad_status) else $error("misplaced list not failed");

  property p_good_status;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    chk_valid_i && !queue_split_i && !queue_noncontig_i && !list_split_i && !data_split_i && sq_in_buf_i
      |=> !chk_bad_o && chk_status_o == 8'h00;
  endproperty
  a_good_status: assert property (p_good_status) else $error("legal placement failed");

  property p_split_queue;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    chk_valid_i && (queue_split_i || queue_noncontig_i) |=> chk_bad_o;
  endproperty
  a_split_queue: assert property (p_split_queue) else $error("split queue not failed");

  property p_read_returns;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    state_q == cmb_pkg::CMB_IDLE && req_hit_o && !req_write_i && req_len_i == 6'h01 && cpl_ready_i
      |=> ##1 cpl_valid_o && cpl_last_o;
  endproperty
  a_read_returns: assert property (p_read_returns) else $error("read completion missing");

  property p_miss_ignored;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    state_q == cmb_pkg::CMB_IDLE && req_valid_i && !req_hit_o |=> state_q == cmb_pkg::CMB_IDLE;
  endproperty
  a_miss_ignored: assert property (p_miss_ignored) else $error("miss started a transfer");

  property p_write_len;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    state_q == cmb_pkg::CMB_IDLE && req_hit_o && req_write_i && req_len_i == 6'h02
      ##1 req_valid_i ##1 req_valid_i |=> state_q == cmb_pkg::CMB_IDLE;
  endproperty
  a_write_len: assert property (p_write_len) else $error("burst length wrong");

  property p_base_align;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    window_base_i[11:0] != 12'h000 |-> !base_ok_o;
  endproperty
  a_base_align: assert property (p_base_align) else $error("misaligned base accepted");

  property p_support;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    support_o[cmb_pkg::SUP_SQ_POS] && support_o[cmb_pkg::SUP_CQ_POS];
  endproperty
  a_support: assert property (p_support) else $error("queue support flag missing");

endmodule

// ===== shared/cmb_pkg.sv
// Constants and types shared by the controller memory buffer design files.
// Assumes a single 250 MHz controller clock and an asynchronous active-low reset.
package cmb_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int unsigned BUF_ADDR_W = 12;
  localparam int unsigned BUF_WORDS = 1024;
  localparam int unsigned WORD_BYTES = 4;
  localparam int unsigned HOST_ADDR_W = 32;
  localparam int unsigned ALIGN_MIN_BITS = 12;
  localparam int unsigned ALIGN_PREF_BITS = 13;
  localparam int unsigned MAX_PAYLOAD_WORDS = 32;
  localparam int unsigned LEN_W = 6;
  localparam logic [31:0] WINDOW_BASE_RST = 32'h0001_0000;

  // ----------------------------------------------------------------
  // Support flags and status
  // ----------------------------------------------------------------
  localparam int unsigned SUP_SQ_POS = 0;
  localparam int unsigned SUP_CQ_POS = 1;
  localparam int unsigned SUP_LIST_POS = 2;
  localparam int unsigned SUP_RD_DATA_POS = 3;
  localparam int unsigned SUP_WR_DATA_POS = 4;
  localparam logic [4:0] SUPPORT_FLAGS = 5'h1f;
  localparam logic [7:0] STATUS_SUCCESS = 8'h00;
  localparam logic [7:0] STATUS_INVALID_CMB_USE = 8'h2a;

  typedef enum logic [1:0] {
    CMB_IDLE = 2'b00,
    CMB_WRITE = 2'b01,
    CMB_READ = 2'b10
  } cmb_state_type;

endpackage

// ===== tb/cmb_host_model.sv
// Host requester model: issues window reads and writes and accepts completions.
// Assumes one shared clock; every request change lands 1 ns after a rising edge.
module cmb_host_model (
  // Clock
  input wire logic ref_clk_i,
  // Request side
  input wire logic req_ready_i,
  input wire logic req_hit_i,
  output logic req_valid_o,
  output logic req_write_o,
  output logic [31:0] req_addr_o,
  output logic [5:0] req_len_o,
  output logic [3:0] req_first_be_o,
  output logic [3:0] req_last_be_o,
  output logic [31:0] req_wdata_o,
  // Completion side
  input wire logic cpl_valid_i,
  input wire logic [31:0] cpl_data_i,
  input wire logic cpl_last_i,
  output logic cpl_ready_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] rd_q[$];
  logic last_q[$];
  int tmo = 0;

  initial begin
    {req_valid_o, req_write_o, req_addr_o, req_len_o} = '0;
    {req_first_be_o, req_last_be_o, req_wdata_o, cpl_ready_o} = '0;
  end

  // Completions are accepted at random to stall the burst now and then.
  always @(posedge ref_clk_i) begin
    if (cpl_valid_i && cpl_ready_o) begin
      rd_q.push_back(cpl_data_i);
      last_q.push_back(cpl_last_i);
    end
    #1 cpl_ready_o = 1'($urandom);
  end

  // Requests are issued one at a time and each ends before the next, so all
  // buffer writes reach the memory in the order they are issued.
  task automatic send(input logic wr, input logic [31:0] addr, input logic [5:0] len,
                      input logic [3:0] fbe, input logic [3:0] lbe, input logic [31:0] data[$], input int lim);
    int n;
    req_valid_o = 1'b1;
    req_write_o = wr;
    req_addr_o = addr;
    req_len_o = len;
    req_first_be_o = fbe;
    req_last_be_o = lbe;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (!(req_ready_i && req_hit_i) && n < lim);
    if (n >= lim) tmo++;
    #1;
    if (wr && n < lim) begin
      foreach (data[i]) begin
        req_wdata_o = data[i];
        do @(posedge ref_clk_i); while (!req_ready_i);
        #1;
      end
      // Released data lines must not keep showing the last beat.
      req_wdata_o = ~req_wdata_o;
    end
    req_valid_o = 1'b0;
    // One idle edge between requests keeps each strobe change to one per time step.
    @(posedge ref_clk_i);
    #1;
  endtask
endmodule

// ===== tb/controller_memory_buffer_tb_top.sv
// Self-checking bench for the controller memory buffer top level.
// Assumes the host model drives the request ports and cpl_ready_i, and the bench drives the rest.
`define CHK(nm, e, g) begin num_checks++; if ((e) !== (g)) begin bad_count++; $display("BAD %s exp %h got %h", nm, e, g); end end
module controller_memory_buffer_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [31:0] window_base_i = cmb_pkg::WINDOW_BASE_RST;
  logic [4:0] support_o;
  logic base_ok_o, req_valid_i, req_ready_o, req_write_i, req_hit_o;
  logic [31:0] req_addr_i, req_wdata_i, cpl_data_o, int_rdata_o;
  logic [5:0] req_len_i;
  logic [3:0] req_first_be_i, req_last_be_i;
  logic cpl_valid_o, cpl_ready_i, cpl_last_o, int_rd_i = 1'b0;
  logic [9:0] int_word_i = '0;
  logic [6:0] f = '0;
  logic chk_valid_i = 1'b0;
  logic chk_done_o, chk_bad_o;
  logic [7:0] chk_status_o;
  logic [31:0] mdl [1024];
  logic [31:0] base;
  logic [31:0] nodata[$];
  logic exp_bad;
  int bad_count = 0;
  int num_checks = 0;
  int w;

  always #2 ref_clk_i = ~ref_clk_i;

  cmb_top uut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .window_base_i(window_base_i), .support_o(support_o),
    .base_ok_o(base_ok_o), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_write_i(req_write_i),
    .req_addr_i(req_addr_i), .req_len_i(req_len_i), .req_first_be_i(req_first_be_i),
    .req_last_be_i(req_last_be_i), .req_wdata_i(req_wdata_i), .req_hit_o(req_hit_o), .cpl_valid_o(cpl_valid_o),
    .cpl_ready_i(cpl_ready_i), .cpl_data_o(cpl_data_o), .cpl_last_o(cpl_last_o), .int_rd_i(int_rd_i),
    .int_word_i(int_word_i), .int_rdata_o(int_rdata_o), .chk_valid_i(chk_valid_i), .sq_in_buf_i(f[6]),
    .list_in_buf_i(f[5]), .list_split_i(f[4]), .data_in_buf_i(f[3]), .data_split_i(f[2]),
    .queue_split_i(f[1]), .queue_noncontig_i(f[0]), .chk_done_o(chk_done_o), .chk_bad_o(chk_bad_o),
    .chk_status_o(chk_status_o));

  cmb_host_model host (.ref_clk_i(ref_clk_i), .req_ready_i(req_ready_o), .req_hit_i(req_hit_o),
    .req_valid_o(req_valid_i), .req_write_o(req_write_i), .req_addr_o(req_addr_i), .req_len_o(req_len_i),
    .req_first_be_o(req_first_be_i), .req_last_be_o(req_last_be_i), .req_wdata_o(req_wdata_i),
    .cpl_valid_i(cpl_valid_o), .cpl_data_i(cpl_data_o), .cpl_last_i(cpl_last_o), .cpl_ready_o(cpl_ready_i));

  // ----------------------------------------------------------------
  // Transfer tasks with the reference memory
  // ----------------------------------------------------------------
  task automatic do_wr(input logic [31:0] a, input int len, input logic [3:0] fb, input logic [3:0] lb);
    logic [31:0] d[$];
    logic [3:0] be;
    int x;
    for (int i = 0; i < len; i++) begin
      d.push_back($urandom);
      be = (i == 0) ? fb : 4'hf;
      if (i == len - 1) be &= lb;
      x = (a[11:2] + i) % 1024;
      for (int b = 0; b < 4; b++) if (be[b]) mdl[x][8*b+:8] = d[i][8*b+:8];
    end
    host.send(1'b1, a, 6'(len), fb, lb, d, 200);
  endtask

  task automatic do_rd(input logic [31:0] a, input int len);
    int n;
    host.rd_q.delete();
    host.last_q.delete();
    host.send(1'b0, a, 6'(len), 4'hf, 4'hf, nodata, 200);
    n = 0;
    while (host.rd_q.size() < len && n < 500) begin
      @(posedge ref_clk_i);
      n++;
    end
    #1;
    for (int i = 0; i < len; i++) begin
      `CHK("rdata", mdl[(a[11:2] + i) % 1024], host.rd_q[i])
      `CHK("cpl_last", (i == len - 1), host.last_q[i])
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(9));
    base = cmb_pkg::WINDOW_BASE_RST;
    repeat (6) @(posedge ref_clk_i);
    #1 nrst_i = 1'b1;
    `CHK("support", cmb_pkg::SUPPORT_FLAGS, support_o)
    `CHK("base_ok", 1'b1, base_ok_o)
    // Contents are undefined after reset, so every word is written before any read.
    for (int k = 0; k < 32; k++) do_wr(base + k * 128, 32, 4'hf, 4'hf);
    for (int k = 0; k < 40; k++) begin
      do_wr(base | ($urandom & 32'hfff), $urandom_range(32, 1), 4'($urandom), 4'($urandom));
      do_rd(base | ($urandom & 32'hfff), $urandom_range(32, 1));
    end
    do_wr(base + 32'h0000_0008, 2, 4'h3, 4'hc);
    do_rd(base + 32'h0000_0008, 2);
    do_rd(base, 1);
    for (int k = 0; k < 8; k++) begin
      w = $urandom_range(1023, 0);
      int_rd_i = 1'b1;
      int_word_i = 10'(w);
      @(posedge ref_clk_i);
      #1 `CHK("int_rdata", mdl[w], int_rdata_o)
    end
    int_rd_i = 1'b0;
    host.rd_q.delete();
    fork
      host.send(1'b0, base ^ 32'h0000_1000, 6'h01, 4'hf, 4'hf, nodata, 8);
      begin
        repeat (2) @(posedge ref_clk_i);
        `CHK("miss_hit", 1'b0, req_hit_o)
      end
    join
    repeat (4) @(posedge ref_clk_i);
    `CHK("miss_cpl", 1'b1, host.rd_q.size() == 0)
    #1 window_base_i = base | 32'h0000_0800;
    @(posedge ref_clk_i);
    `CHK("base_ok_unal", 1'b0, base_ok_o)
    #1 window_base_i = 32'h0000_2000;
    @(posedge ref_clk_i);
    `CHK("base_ok_8k", 1'b1, base_ok_o)
    #1;
    for (int k = 0; k < 4; k++) do_rd(32'h0000_2000 | ($urandom & 32'hffc), 4);
    // Every placement combination, one per cycle with the strobe held up.
    @(posedge ref_clk_i);
    for (int k = 0; k < 128; k++) begin
      #1 f = 7'(k);
      chk_valid_i = 1'b1;
      exp_bad = f[4] | f[2] | f[1] | f[0] | (f[5] & !f[6]);
      @(posedge ref_clk_i);
      #1 `CHK("chk_done", 1'b1, chk_done_o)
      `CHK("chk_bad", exp_bad, chk_bad_o)
      `CHK("chk_status", exp_bad ? cmb_pkg::STATUS_INVALID_CMB_USE : cmb_pkg::STATUS_SUCCESS, chk_status_o)
    end
    chk_valid_i = 1'b0;
    @(posedge ref_clk_i);
    #1 `CHK("chk_done_end", 1'b0, chk_done_o)
    // Only the deliberate miss may run out of its wait; any other expiry is a hang.
    `CHK("send_tmo", 1, host.tmo)
    complete_run;
  end

  initial begin
    #200000;
    bad_count++;
    complete_run;
  end
endmodule
